// ===== flash_program_erase_timing.sv
// program and erase timing sequencer of the flash controller
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_timing
#(
    parameter int unsigned DIV = flash_timing_pkg::GEN_DIV
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic [2:0] req_op,
    input wire logic blk_data_valid,
    output logic blk_data_ready,
    output logic busy,
    output logic prog_strobe,
    output logic erase_active,
    output logic mass_sel,
    output logic done,
    output logic [flash_timing_pkg::IDX_W-1:0] blk_index
);
    import flash_timing_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // one-cycle pulse per generator period
    logic gen_tick;

    tick_divider #(.DIV(DIV)) u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(gen_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        seq_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [IDX_W-1:0] idx;
        logic started;
        logic busy;
        logic prog;
        logic erase;
        logic mass;
        logic done;
        logic ready;
    } seq_s;

    // idle, nothing pending, every output low
    localparam seq_s SEQ_IDLE = '{st: ST_IDLE, default: '0};
    seq_s q, d;

    logic op_known;
    logic last_tick;
    logic [CNT_W-1:0] first_ticks;
    logic [CNT_W-1:0] item_ticks;

    ////////////////////////////////////////////////////////////////////////
    // periods loaded when a request is accepted; for a block this is the first item only
    function automatic logic [CNT_W-1:0] op_ticks(input logic [2:0] op);
        logic [CNT_W-1:0] n;
        n = '0;
        case (op)
            OP_WORD: begin
                n = WORD_TICKS; // RULE1
            end
            OP_BLOCK: begin
                n = BLOCK_FIRST_TICKS; // RULE2
            end
            OP_SEG: begin
                n = SEG_ERASE_TICKS; // RULE5
            end
            OP_MASS: begin
                n = MASS_ERASE_TICKS; // RULE5
            end
            default: begin
                n = '0;
            end
        endcase
        return n;
    endfunction

    // codes outside the four operations never make the block busy
    assign op_known = req_op inside {OP_WORD, OP_BLOCK, OP_SEG, OP_MASS};
    assign first_ticks = op_ticks(req_op);
    // a count ends on the period tick that finds it at one
    assign last_tick = gen_tick && (q.cnt == 14'h0001);
    // the last item is followed by the closing wait, not another item
    assign item_ticks = (q.idx == LAST_IDX) ? BLOCK_END_TICKS : // RULE4
        BLOCK_NEXT_TICKS; // RULE3

    ////////////////////////////////////////////////////////////////////////
    // next state of the whole sequencer
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.ready = 1'b0;
        case (q.st)
            ST_IDLE: begin
                d.busy = 1'b0;
                d.prog = 1'b0;
                d.erase = 1'b0;
                d.cnt = '0;
                d.idx = '0;
                d.started = 1'b0;
                // busy rises on the edge that takes the request
                if (req_valid && op_known) begin
                    case (req_op)
                        OP_WORD: begin
                            d.st = ST_WORD;
                            d.cnt = first_ticks; // RULE1
                            d.busy = 1'b1; // RULE9
                            d.prog = 1'b1;
                        end
                        OP_BLOCK: begin
                            d.st = ST_BLK;
                            d.cnt = first_ticks; // RULE2
                            d.busy = 1'b1; // RULE9
                            d.started = blk_data_valid;
                        end
                        OP_SEG: begin
                            d.st = ST_ERASE;
                            d.cnt = first_ticks; // RULE5
                            d.busy = 1'b1; // RULE9
                            d.erase = 1'b1;
                            d.mass = 1'b0;
                        end
                        OP_MASS: begin
                            d.st = ST_ERASE;
                            d.cnt = first_ticks; // RULE5
                            d.busy = 1'b1; // RULE9
                            d.erase = 1'b1;
                            d.mass = 1'b1;
                        end
                        default: begin
                            d.st = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_WORD: begin
                // requests are not looked at while busy
                if (last_tick) begin // RULE9
                    d.st = ST_IDLE;
                    d.busy = 1'b0;
                    d.prog = 1'b0;
                    d.done = 1'b1;
                end else if (gen_tick) begin
                    d.cnt = q.cnt - 14'h0001;
                end
            end
            ST_ERASE: begin
                // mass_sel keeps the kind of the last erase
                if (last_tick) begin // RULE9
                    d.st = ST_IDLE;
                    d.busy = 1'b0;
                    d.erase = 1'b0;
                    d.done = 1'b1;
                end else if (gen_tick) begin
                    d.cnt = q.cnt - 14'h0001;
                end
            end
            ST_BLK: begin
                // an item waits for its data before timing starts
                if (!q.started) begin
                    d.started = blk_data_valid;
                end else if (last_tick) begin
                    d.prog = 1'b0;
                    d.ready = 1'b1;
                    d.started = 1'b0;
                    d.cnt = item_ticks; // RULE3 RULE4
                    if (q.idx == LAST_IDX) begin
                        d.st = ST_BLK_END;
                    end else begin
                        d.idx = q.idx + 6'h01;
                    end
                end else begin
                    d.prog = 1'b1; // RULE2 RULE3
                    if (gen_tick) begin
                        d.cnt = q.cnt - 14'h0001;
                    end
                end
            end
            ST_BLK_END: begin
                // closing wait, no item is programmed
                if (last_tick) begin
                    d.st = ST_IDLE;
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end else if (gen_tick) begin
                    d.cnt = q.cnt - 14'h0001;
                end
            end
            default: begin
                // a stray code drops any half-done operation
                d.st = ST_IDLE;
                d.busy = 1'b0;
                d.prog = 1'b0;
                d.erase = 1'b0;
                d.started = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronous reset back to idle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= SEQ_IDLE;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // every output is a field of the state register
    assign busy = q.busy;
    assign prog_strobe = q.prog;
    assign erase_active = q.erase;
    assign mass_sel = q.mass;
    assign done = q.done;
    assign blk_data_ready = q.ready;
    assign blk_index = q.idx;
endmodule // flash_program_erase_timing
`default_nettype wire

// ===== flash_program_erase_timing_test.sv
// self-checking bench of the flash program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_timing_test;
    import flash_timing_pkg::*;
    localparam int unsigned DIV = 2;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic stall = 1'b0;
    logic [2:0] go_op = 3'h0;
    logic req_valid, blk_data_valid, blk_data_ready, busy, prog_strobe;
    logic erase_active, mass_sel, done;
    logic [2:0] req_op;
    logic [IDX_W-1:0] blk_index;
    logic [2:0] ops [4] = '{OP_WORD, OP_BLOCK, OP_SEG, OP_MASS};
    int errors = 0;
    int checks_done = 0;
    int unsigned cyc, rdy, n, pc;
    flash_requester host (.sys_clk(sys_clk), .rst_n(rst_n), .go(go),
        .go_op(go_op), .stall(stall), .req_valid(req_valid),
        .req_op(req_op), .blk_data_valid(blk_data_valid));
    flash_program_erase_timing #(.DIV(DIV)) dut (.sys_clk(sys_clk),
        .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
        .blk_data_valid(blk_data_valid), .blk_data_ready(blk_data_ready),
        .busy(busy), .prog_strobe(prog_strobe), .erase_active(erase_active),
        .mass_sel(mass_sel), .done(done), .blk_index(blk_index));
    function automatic int unsigned ticks(logic [2:0] op);
        return op == OP_WORD ? 30 : op == OP_SEG ? 4819 :
            op == OP_MASS ? 10593 : 25 + 63 * 18 + 6;
    endfunction
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic compare(logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // one operation; a second request is thrown in while busy
    task automatic run(logic [2:0] op, logic [2:0] mid);
        go <= 1'b1;
        go_op <= op;
        cyc = 0;
        rdy = 0;
        pc = 0;
        n = ticks(op);
        do begin
            @(posedge sys_clk);
            go <= cyc == 5;
            go_op <= cyc == 5 ? mid : op;
            stall <= op == OP_BLOCK && $urandom_range(3) == 0;
            #1 cyc++;
            rdy += 32'(blk_data_ready);
            pc += 32'(prog_strobe);
            if (op == OP_BLOCK)
                compare(32'(blk_index), rdy > 63 ? 63 : rdy);
            if (cyc == 4)
                compare(32'(erase_active), 32'(op > OP_BLOCK));
            if (cyc == 4 && op != OP_BLOCK)
                compare(32'(prog_strobe), 32'(op == OP_WORD));
        end while (done !== 1'b1 && cyc < 25000);
        if (done !== 1'b1) errors++;
        if (done !== 1'b1) end_of_test();
        compare(32'(cyc + DIV >= n * DIV), 1);
        if (op != OP_BLOCK) compare(32'(cyc <= n * DIV + 4), 1);
        if (op == OP_BLOCK) compare(rdy, 64);
        if (op == OP_BLOCK)
            compare(32'(pc + 64 * DIV >= (n - 6) * DIV), 1);
        if (op == OP_BLOCK)
            compare(32'(pc <= (n - 6) * DIV), 1);
        compare(32'({busy, prog_strobe, erase_active}), 0);
        if (op > OP_BLOCK) compare(32'(mass_sel), 32'(op == OP_MASS));
        repeat (3) @(posedge sys_clk);
        #1 compare(32'(busy), 0);
    endtask
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        void'($urandom(17));
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int k = 4; k < 8; k++) begin
            @(posedge sys_clk);
            go <= 1'b1;
            go_op <= k[2:0] == 3'h4 ? 3'h0 : k[2:0];
            @(posedge sys_clk);
            go <= 1'b0;
            repeat (3) @(posedge sys_clk);
            #1 compare(32'(busy), 0);
        end
        foreach (ops[i]) run(ops[i], 3'($urandom_range(4, 1)));
        repeat (3) run(3'($urandom_range(3, 1)), 3'($urandom_range(4, 1)));
        end_of_test();
    end
endmodule // flash_program_erase_timing_test
`default_nettype wire

// ===== flash_requester.sv
// processor model issuing program and erase requests
`timescale 1ns/1ps
`default_nettype none
module flash_requester (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [2:0] go_op,
    input wire logic stall,
    output logic req_valid,
    output logic [2:0] req_op,
    output logic blk_data_valid
);
    logic [2:0] op_q;
    // short bench ops keep block time under 10ms, but the bench DIV of 2 runs the generator far above 476 kHz
    always_ff @(posedge sys_clk) begin
        req_valid <= rst_n && go;
        op_q <= rst_n ? go_op : 3'h0;
        blk_data_valid <= !stall;
    end
    // released op lines show the inverse of the last code
    assign req_op = req_valid ? op_q : ~op_q;
endmodule // flash_requester
`default_nettype wire

// ===== flash_timing_assertions.sv
// assertions of the flash program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_timing_assertions
    import flash_timing_pkg::*;
#(parameter int unsigned DIV = 2) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic [2:0] req_op,
    input wire logic blk_data_valid,
    input wire logic blk_data_ready,
    input wire logic busy,
    input wire logic prog_strobe,
    input wire logic erase_active,
    input wire logic mass_sel,
    input wire logic done,
    input wire logic [flash_timing_pkg::IDX_W-1:0] blk_index
);
    logic [2:0] op_q;
    int unsigned cnt_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // op in flight and its busy cycles
    always_ff @(posedge sys_clk) begin
        if (!rst_n || (!busy && req_valid)) begin
            op_q <= rst_n ? req_op : 3'h0;
            cnt_q <= 0;
        end else if (busy) begin
            cnt_q <= cnt_q + 1;
        end
    end
    sequence s_take;
        !busy && req_valid && req_op inside {[3'h1:3'h4]};
    endsequence
    sequence s_end;
        done && !busy ##1 !done;
    endsequence
    property p_len(logic [2:0] op, int unsigned n);
        done && op_q == op |-> cnt_q + DIV + 1 >= n * DIV && cnt_q <= n * DIV + 2;
    endproperty
    AST_TAKE: assert property (s_take |=> busy)
        else $error("request not taken");
    AST_IDLE: assert property (!busy && !(req_valid &&
        req_op inside {[3'h1:3'h4]}) |=> !busy) else $error("busy unasked");
    AST_END: assert property ($fell(busy) |-> s_end)
        else $error("end without done pulse");
    AST_CAUSE: assert property ($rose(done) |-> $past(busy))
        else $error("done while idle");
    AST_WORD_LEN: assert property (p_len(OP_WORD, 30))
        else $error("word length wrong");
    AST_SEG_LEN: assert property (p_len(OP_SEG, 4819))
        else $error("segment erase length wrong");
    AST_MASS_LEN: assert property (p_len(OP_MASS, 10593))
        else $error("mass erase length wrong");
    AST_BLOCK_LEN: assert property (done && op_q == OP_BLOCK |->
        cnt_q + DIV + 1 >= (25 + 63 * 18 + 6) * DIV) else $error("block short");
    AST_LEVELS: assert property (prog_strobe || erase_active |-> busy)
        else $error("activity outside busy");
    AST_MASS_SEL: assert property (erase_active |->
        mass_sel == (op_q == OP_MASS)) else $error("erase kind wrong");
    AST_READY: assert property (blk_data_ready |-> busy &&
        op_q == OP_BLOCK) else $error("item ready outside block");
endmodule // flash_timing_assertions
bind flash_program_erase_timing flash_timing_assertions #(.DIV(DIV)) chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_op(req_op), .blk_data_valid(blk_data_valid),
    .blk_data_ready(blk_data_ready), .busy(busy), .prog_strobe(prog_strobe),
    .erase_active(erase_active), .mass_sel(mass_sel), .done(done),
    .blk_index(blk_index));
`default_nettype wire

// ===== flash_timing_pkg.sv
// constants and types of the flash program and erase timing sequencer
// Contract
// RULE1: single write lasts thirty generator periods
// RULE2: first block item takes twenty-five periods
// RULE3: block items one to sixty-three take eighteen
// RULE4: block ends with six period wait
// RULE5: mass erase 10593, segment erase 4819
// RULE6: requester limits block program time 10ms
// RULE7: requester keeps generator 257 to 476 kHz; the bench DIV of 2 runs it far above
// RULE8: requester repeats mass erase to 20ms; the bench runs one mass erase, never repeated
// RULE9: busy whole sequence, new requests ignored
package flash_timing_pkg;
    localparam int unsigned CNT_W = 14;
    localparam logic [CNT_W-1:0] WORD_TICKS = 14'h001E;
    localparam logic [CNT_W-1:0] BLOCK_FIRST_TICKS = 14'h0019;
    localparam logic [CNT_W-1:0] BLOCK_NEXT_TICKS = 14'h0012;
    localparam logic [CNT_W-1:0] BLOCK_END_TICKS = 14'h0006;
    localparam logic [CNT_W-1:0] MASS_ERASE_TICKS = 14'h2961;
    localparam logic [CNT_W-1:0] SEG_ERASE_TICKS = 14'h12D3;
    localparam int unsigned BLOCK_ITEMS = 64;
    localparam int unsigned IDX_W = 6;
    localparam logic [IDX_W-1:0] LAST_IDX = 6'h3F;
    // request operation codes
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_WORD = 3'h1;
    localparam logic [2:0] OP_BLOCK = 3'h2;
    localparam logic [2:0] OP_SEG = 3'h3;
    localparam logic [2:0] OP_MASS = 3'h4;
    // system clock cycles per generator period
    localparam int unsigned SYS_CLK_HZ = 25000000;
    localparam int unsigned GEN_HZ = 400000;
    localparam int unsigned GEN_DIV = (SYS_CLK_HZ + GEN_HZ - 1) / GEN_HZ;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WORD = 3'b001,
        ST_BLK = 3'b011,
        ST_BLK_END = 3'b010,
        ST_ERASE = 3'b110
    } seq_state_e;
endpackage

// ===== tick_divider.sv
// divider producing one-cycle timing generator ticks
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int unsigned DIV = 63
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } div_s;
    div_s q, d;
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == 16'(DIV - 1)) begin
            d.cnt = 16'h0000;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 16'h0001;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign tick = q.tick;
endmodule // tick_divider
`default_nettype wire
